// ---- bench/ssra_afe_model.sv ----
// Front-end model: answers each conversion request with the code set for that LED
module ssra_afe_model (
	// Clock
	input wire logic aclk,
	// Block side
	input wire ssra_pkg::ssra_led_t led_out,
	output ssra_pkg::ssra_adc_t adc_in,
	// Bench control
	input wire logic [3:0] lat,
	input wire logic [29:0] codes
);
	import ssra_pkg::*;
	logic [1:0] sel;
	logic [9:0] last;
	////////////////////////////////////////////////////////////////
	initial begin
		adc_in = '{valid: 1'b0, code: 10'h155};
	end
	// Waits a bench-set latency, pulses valid, then scrambles the idle code
	always @(posedge aclk) begin
		if (led_out.start === 1'b1) begin
			sel = led_out.sel;
			repeat (lat) @(posedge aclk);
			last = codes[sel * 10 +: 10];
			adc_in <= '{valid: 1'b1, code: last};
			@(posedge aclk);
			adc_in <= '{valid: 1'b0, code: ~last};
		end
	end
endmodule

// ---- bench/ssra_top_tb_top.sv ----
// Self-checking bench for the smoke scatter readout and alarm block
module ssra_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import ssra_pkg::*;
	localparam int unsigned SLOW = 400;
	localparam int unsigned FAST = 200;
	typedef struct packed {
		logic [1:0] resp;
		logic [31:0] data;
		logic [31:0] mask;
	} ssra_exp_t;
	logic aclk, aresetn, clk_en, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, frontend_enable, offset_comp_active, alarm, nuisance, irq;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb, lat;
	logic [1:0] bresp, rresp;
	logic [29:0] codes;
	ssra_adc_t adc_in;
	ssra_led_t led_out;
	ssra_exp_t rq[$];
	logic [1:0] bq[$];
	int mismatches = 0;
	int n_tests = 0;
	int seed = 61343;
	////////////////////////////////////////////////////////////////
	ssra_top #(.SLOW_CYC(SLOW), .FAST_CYC(FAST)) u_dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .adc_in(adc_in),
		.led_out(led_out), .frontend_enable(frontend_enable), .offset_comp_active(offset_comp_active),
		.alarm(alarm), .nuisance(nuisance), .irq(irq));
	ssra_afe_model u_afe (.aclk(aclk), .led_out(led_out), .adc_in(adc_in), .lat(lat), .codes(codes));
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	////////////////////////////////////////////////////////////////
	task automatic note(input logic ok, input logic [33:0] got, input logic [33:0] exp);
		n_tests++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_rd(input logic [33:0] got, input ssra_exp_t e);
		note((got & {2'b11, e.mask}) === {e.resp, e.data & e.mask}, got, {e.resp, e.data});
	endtask
	task automatic chk_bresp(input logic [1:0] got, input logic [1:0] e);
		note(got === e, 34'(got), 34'(e));
	endtask
	task automatic chk_pin(input logic got, input logic e);
		note(got === e, 34'(got), 34'(e));
	endtask
	// Watches the answer channels and pairs each answer with its oldest note
	always @(posedge aclk) begin
		if (rvalid === 1'b1 && rready === 1'b1) begin
			if (rq.size() == 0) note(1'b0, {rresp, rdata}, 34'h0);
			else chk_rd({rresp, rdata}, rq.pop_front());
		end
		if (bvalid === 1'b1 && bready === 1'b1) begin
			if (bq.size() == 0) note(1'b0, 34'(bresp), 34'h0);
			else chk_bresp(bresp, bq.pop_front());
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic wr(input logic [4:0] idx, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
		bq.push_back(er);
		awaddr <= {1'b0, idx, 2'b00};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [4:0] idx, input logic [31:0] d, input logic [31:0] m = 32'hffff_ffff,
		input logic [1:0] er = RESP_OKAY);
		rq.push_back('{resp: er, data: d, mask: m});
		araddr <= {1'b0, idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic wait_irq();
		int n;
		for (n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge aclk);
		if (n == 3000) begin
			mismatches++;
			wrap_up();
		end
	endtask
	// One three-LED scan with the given codes, then the verdict pins and status
	task automatic scan(input logic [9:0] rf, bf, rb, input logic ea, en, ef);
		// Let the scan in progress end so that no scan mixes old and new codes
		wr(REG_IRQ_STAT, 32'h0000_000f);
		wait_irq();
		codes <= {rb, bf, rf};
		lat <= 4'($random(seed));
		wr(REG_IRQ_STAT, 32'h0000_000f);
		wait_irq();
		chk_pin(alarm, ea);
		chk_pin(nuisance, en);
		rd(REG_STATUS, {29'h0, en, ea, ef}, 32'h0000_0007);
	endtask
	task automatic wrap_up();
		$display("Checks made: %0d, mismatches: %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		int i, v;
		logic [7:0] g;
		{aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
		clk_en = 1'b1;
		wstrb = 4'hf;
		lat = 4'h8;
		codes = {10'h064, 10'h064, 10'h064};
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(REG_GAIN, 32'h0000_0026);
		rd(REG_WAKE, 32'h0000_0078);
		rd(REG_CLASS, 32'h0000_00c8);
		rd(REG_ALARM, 32'h0000_0122);
		rd(5'h15, 32'h0000_0000, 32'hffff_ffff, RESP_SLVERR);
		wr(5'h15, 32'h0000_00ff, RESP_SLVERR);
		for (i = 0; i < 4; i++) begin
			g = 8'($random(seed)) & 8'h1f;
			wr(REG_GAIN, {24'h0, g});
			rd(REG_GAIN, {24'h0, g});
		end
		wr(REG_GAIN, 32'h0000_0005);
		wr(REG_OFFSET, 32'h0000_0014);
		for (i = 0; i < 3; i++) wr(REG_DIRECT + 5'(i), 32'(500 + 100 * i));
		wr(REG_IRQ_MASK, 32'h0000_0008);
		wr(REG_CTRL, 32'h0000_0001);
		repeat (3) @(posedge aclk);
		chk_pin(frontend_enable, 1'b1);
		chk_pin(offset_comp_active, 1'b1);
		wr(REG_GAIN, 32'h0000_0015);
		repeat (3) @(posedge aclk);
		chk_pin(offset_comp_active, 1'b0);
		for (i = 0; i < 1000 && led_out.on !== 1'b1; i++) @(posedge aclk);
		repeat (3) @(posedge aclk);
		chk_pin(offset_comp_active, 1'b1);
		repeat (100) @(posedge aclk);
		rd(REG_STATUS, 32'h0000_0000, 32'h0000_0007);
		codes <= {10'h064, 10'h064, 10'h082};
		wr(REG_IRQ_STAT, 32'h0000_000f);
		wait_irq();
		rd(REG_STATUS, 32'h0000_0001, 32'h0000_0007);
		rd(REG_IRQ_STAT, 32'h0000_0009, 32'h0000_000f);
		wr(REG_IRQ_MASK, 32'h0000_0000);
		repeat (2) @(posedge aclk);
		chk_pin(irq, 1'b0);
		wr(REG_IRQ_MASK, 32'h0000_000f);
		repeat (2) @(posedge aclk);
		chk_pin(irq, 1'b1);
		scan(10'h096, 10'h12c, 10'h0c8, 1'b0, 1'b0, 1'b1);
		scan(10'h096, 10'h064, 10'h0fa, 1'b0, 1'b1, 1'b1);
		rd(REG_IRQ_STAT, 32'h0000_000c, 32'h0000_000f);
		scan(10'h096, 10'h190, 10'h0fa, 1'b1, 1'b0, 1'b1);
		for (i = 0; i < 3; i++) begin
			v = (i == 0) ? 150 : (i == 1) ? 400 : 250;
			rd(REG_RAW + 5'(i), 32'(v));
			rd(REG_CURR + 5'(i), 32'((v - 20) * 2000 / 20));
			rd(REG_RATIO + 5'(i), 32'(((v - 20) << 16) / (480 + 100 * i)));
		end
		scan(10'h122, 10'h064, 10'h096, 1'b0, 1'b0, 1'b1);
		scan(10'h123, 10'h064, 10'h096, 1'b1, 1'b0, 1'b1);
		rd(REG_IRQ_STAT, 32'h0000_000a, 32'h0000_000f);
		scan(10'h064, 10'h064, 10'h064, 1'b0, 1'b0, 1'b0);
		wrap_up();
	end
	initial begin
		#(20_000 * 100);
		mismatches++;
		wrap_up();
	end
endmodule

// ---- include/ssra_pkg.sv ----
// Constants and types shared by the smoke scatter readout and alarm block
package ssra_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int SLOW_PERIOD_S = 6;
	localparam int FAST_PERIOD_S = 2;
	localparam int SLOW_CYCLES = SLOW_PERIOD_S * CLK_HZ;
	localparam int FAST_CYCLES = FAST_PERIOD_S * CLK_HZ;
	localparam int ADC_W = 10;
	localparam int ADC_FULL = 1024;
	localparam int VREF_MV = 2048;
	// Photocurrent in pA = code delta * PA_PER_CODE / gain product
	localparam int PA_PER_CODE = VREF_MV * 1000 / ADC_FULL;
	localparam int RATIO_FRAC = 16;
	localparam int ADDR_W = 8;
	localparam int NUM_LEDS = 3;
	localparam logic [5:0] DIV_STEPS = 6'h20;
	// Register indices, byte address is index times four
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_GAIN = 5'h01;
	localparam logic [4:0] REG_WAKE = 5'h02;
	localparam logic [4:0] REG_CLASS = 5'h03;
	localparam logic [4:0] REG_ALARM = 5'h04;
	localparam logic [4:0] REG_OFFSET = 5'h05;
	localparam logic [4:0] REG_DIRECT = 5'h06;
	localparam logic [4:0] REG_STATUS = 5'h09;
	localparam logic [4:0] REG_IRQ_STAT = 5'h0a;
	localparam logic [4:0] REG_IRQ_MASK = 5'h0b;
	localparam logic [4:0] REG_RAW = 5'h0c;
	localparam logic [4:0] REG_CURR = 5'h0f;
	localparam logic [4:0] REG_RATIO = 5'h12;
	localparam logic [4:0] REG_LAST = 5'h14;
	// Gain configuration fields
	localparam int GAIN_RSV_LSB = 5;
	localparam int GAIN_OCS_BIT = 4;
	localparam int GAIN_IG_LSB = 2;
	localparam int GAIN_PG_LSB = 0;
	localparam logic [7:0] GAIN_RESET = 8'h26;
	localparam logic [9:0] WAKE_RESET = 10'h078;
	localparam logic [9:0] CLASS_RESET = 10'h0c8;
	localparam logic [9:0] ALARM_RESET = 10'h122;
	// Interrupt event bits
	localparam int EV_WAKE = 0;
	localparam int EV_ALARM = 1;
	localparam int EV_NUIS = 2;
	localparam int EV_SCAN = 3;
	localparam int EV_W = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		LED_RED_FWD = 2'b00,
		LED_BLUE_FWD = 2'b01,
		LED_RED_BACK = 2'b10
	} ssra_led_sel_t;

	typedef enum logic [2:0] {
		ST_WAIT = 3'b000,
		ST_SAMPLE = 3'b001,
		ST_CURR_W = 3'b010,
		ST_RATIO_W = 3'b011,
		ST_DECIDE = 3'b100
	} ssra_state_t;

	typedef struct packed {
		logic valid;
		logic [ADC_W-1:0] code;
	} ssra_adc_t;

	typedef struct packed {
		logic on;
		ssra_led_sel_t sel;
		logic start;
	} ssra_led_t;
endpackage

// ---- rtl/ssra_divider.sv ----
// Serial restoring divider for photocurrent and ratio scaling
module ssra_divider (
	// Clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	// Request
	input wire logic start,
	input wire logic [31:0] num,
	input wire logic [15:0] den,
	// Result
	output logic done,
	output logic [31:0] quo
);
	import ssra_pkg::*;

	typedef struct packed {
		logic busy;
		logic done;
		logic [5:0] cnt;
		logic [15:0] rem;
		logic [31:0] q;
		logic [15:0] den;
	} ssra_div_t;

	ssra_div_t cur;
	ssra_div_t next_cur;
	logic [16:0] trial;

	always_comb begin
		next_cur = cur;
		next_cur.done = 1'b0;
		trial = {cur.rem, cur.q[31]};
		if (!cur.busy) begin
			if (start && den == 16'h0000) begin
				next_cur.q = '1;
				next_cur.done = 1'b1;
			end else if (start) begin
				next_cur.busy = 1'b1;
				next_cur.cnt = DIV_STEPS;
				next_cur.rem = 16'h0000;
				next_cur.q = num;
				next_cur.den = den;
			end
		end else begin
			if (trial >= {1'b0, cur.den}) begin
				next_cur.rem = 16'(trial - {1'b0, cur.den});
				next_cur.q = {cur.q[30:0], 1'b1};
			end else begin
				next_cur.rem = trial[15:0];
				next_cur.q = {cur.q[30:0], 1'b0};
			end
			next_cur.cnt = cur.cnt - 6'h01;
			if (cur.cnt == 6'h01) begin
				next_cur.busy = 1'b0;
				next_cur.done = 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cur <= '0;
		end else if (clk_en) begin
			cur <= next_cur;
		end
	end

	assign done = cur.done;
	assign quo = cur.q;
endmodule

// ---- rtl/ssra_top.sv ----
// Smoke scatter readout, gain configuration and alarm decision
// What this block does
// - Offset compensation bit: zero means always while enabled, one means only while LED lit.
// - Input gain field codes 0..3 mean 1.25 to 5 megohm, reset code 1.
// - PGA gain field codes 0..3 mean 1.6x, 8x, 16x, 32x, reset code 2.
// - Signal is code minus offset, times 2.048 V over 1024, over gain product.
// - Each LED ratio is scattered value over direct value, same conversion for both.
// - Idle: red forward every 6 s; above wake threshold, all three every 2 s.
// - No smoke-type decision, and no alarm except the red forward threshold, until red backward exceeds classify threshold.
// - That suppression keeps cooking smoke below 4.84 %/m from raising an alarm.
// - When classifying, red ratio above blue is nuisance unless red forward is above the alarm threshold, blue above red alarms now.
// - Red forward above the alarm threshold raises the alarm unconditionally.
// - The alarm threshold fires before opacity exceeds 15.47 %/m.
// - Thresholds compare against raw codes that still contain the front-end offset.
//
// Local design decision: register access over AXI4-Lite.
module ssra_top #(
	parameter int unsigned SLOW_CYC = ssra_pkg::SLOW_CYCLES,
	parameter int unsigned FAST_CYC = ssra_pkg::FAST_CYCLES
) (
	// Clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	// AXI4-Lite write
	input wire logic [ssra_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [ssra_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Front end
	input ssra_pkg::ssra_adc_t adc_in,
	output ssra_pkg::ssra_led_t led_out,
	output logic frontend_enable,
	output logic offset_comp_active,
	// Results
	output logic alarm,
	output logic nuisance,
	output logic irq
);
	import ssra_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic arready;
		logic rvalid;
		logic aw_got;
		logic w_got;
		logic [ADDR_W-1:0] aw_addr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [1:0] bresp;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic fe_en;
		logic [7:0] gain;
		logic [9:0] wake_th;
		logic [9:0] class_th;
		logic [9:0] alarm_th;
		logic [9:0] offset;
		logic [NUM_LEDS-1:0][9:0] direct;
		logic [NUM_LEDS-1:0][9:0] raw;
		logic [NUM_LEDS-1:0][31:0] curr;
		logic [NUM_LEDS-1:0][31:0] ratio;
		logic [EV_W-1:0] ev;
		logic [EV_W-1:0] mask;
		logic irq;
		ssra_state_t st;
		ssra_led_sel_t led;
		logic fast;
		logic alarm;
		logic nuis;
		logic classifying;
		logic [31:0] timer;
		logic led_on;
		logic adc_start;
		logic oc_active;
		logic div_start;
	} ssra_regs_t;

	localparam ssra_regs_t Q_RESET = '{
		awready: 1'b1, wready: 1'b1, arready: 1'b1,
		gain: GAIN_RESET, wake_th: WAKE_RESET, class_th: CLASS_RESET, alarm_th: ALARM_RESET,
		st: ST_WAIT, led: LED_RED_FWD, timer: 32'(SLOW_CYC - 1), default: '0
	};

	ssra_regs_t q;
	ssra_regs_t next_q;
	logic div_done;
	logic [31:0] div_quo;
	logic [31:0] div_num;
	logic [15:0] div_den;
	logic [9:0] delta;
	logic [9:0] delta_dir;
	logic [EV_W-1:0] ev_set;
	logic [EV_W-1:0] ev_clr;
	logic [4:0] widx;
	logic [4:0] ridx;
	logic [31:0] rd;
	logic alarm_now;
	logic smoke_now;
	logic nuis_now;
	logic cls_now;

	////////////////////////////////////////////////////////////////////////////////
	// Decoding helpers
	function automatic logic [7:0] gain_product(input logic [7:0] g);
		logic [7:0] pga;
		case (g[GAIN_PG_LSB +: 2])
			2'h0: pga = 8'h02;
			2'h1: pga = 8'h0a;
			2'h2: pga = 8'h14;
			default: pga = 8'h28;
		endcase
		return 8'(({6'h00, g[GAIN_IG_LSB +: 2]} + 8'h01) * pga);
	endfunction

	function automatic logic [9:0] sub_floor(input logic [9:0] a, input logic [9:0] b);
		return (a > b) ? 10'(a - b) : 10'h000;
	endfunction

	function automatic logic [9:0] merge10(input logic [9:0] old, input logic [31:0] d, input logic [3:0] s);
		return {s[1] ? d[9:8] : old[9:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	function automatic logic [4:0] reg_index(input logic [ADDR_W-1:0] a);
		return a[6:2];
	endfunction

	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1] == 1'b0 && a[6:2] <= REG_LAST;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Divider operands
	always_comb begin
		delta = sub_floor(q.raw[q.led], q.offset);
		delta_dir = sub_floor(q.direct[q.led], q.offset);
		if (q.st == ST_RATIO_W) begin
			div_num = {6'h00, delta, 16'h0000};
			div_den = {6'h00, delta_dir};
		end else begin
			div_num = {22'h000000, delta} * 32'(PA_PER_CODE);
			div_den = {8'h00, gain_product(q.gain)};
		end
	end

	ssra_divider u_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.clk_en(clk_en),
		.start(q.div_start),
		.num(div_num),
		.den(div_den),
		.done(div_done),
		.quo(div_quo)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		next_q = q;
		next_q.adc_start = 1'b0;
		next_q.div_start = 1'b0;
		ev_set = '0;
		ev_clr = '0;
		widx = reg_index(q.aw_addr);
		ridx = reg_index(araddr);
		rd = 32'h0000_0000;
		alarm_now = q.raw[LED_RED_FWD] > q.alarm_th;
		cls_now = q.raw[LED_RED_BACK] > q.class_th;
		smoke_now = cls_now && q.ratio[LED_BLUE_FWD] > q.ratio[LED_RED_FWD];
		nuis_now = cls_now && q.ratio[LED_RED_FWD] > q.ratio[LED_BLUE_FWD];

		// Bus write channels
		if (awvalid && q.awready) begin
			next_q.aw_got = 1'b1;
			next_q.aw_addr = awaddr;
		end
		if (wvalid && q.wready) begin
			next_q.w_got = 1'b1;
			next_q.wdata = wdata;
			next_q.wstrb = wstrb;
		end
		if (bready && q.bvalid) begin
			next_q.bvalid = 1'b0;
		end
		if (next_q.aw_got && next_q.w_got && !q.bvalid) begin
			next_q.aw_got = 1'b0;
			next_q.w_got = 1'b0;
			next_q.bvalid = 1'b1;
			next_q.bresp = is_mapped(next_q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
			widx = reg_index(next_q.aw_addr);
			if (is_mapped(next_q.aw_addr)) begin
				unique case (widx)
					REG_CTRL: if (next_q.wstrb[0]) next_q.fe_en = next_q.wdata[0];
					REG_GAIN: if (next_q.wstrb[0]) next_q.gain = next_q.wdata[7:0];
					REG_WAKE: next_q.wake_th = merge10(q.wake_th, next_q.wdata, next_q.wstrb);
					REG_CLASS: next_q.class_th = merge10(q.class_th, next_q.wdata, next_q.wstrb);
					REG_ALARM: next_q.alarm_th = merge10(q.alarm_th, next_q.wdata, next_q.wstrb);
					REG_OFFSET: next_q.offset = merge10(q.offset, next_q.wdata, next_q.wstrb);
					REG_IRQ_STAT: if (next_q.wstrb[0]) ev_clr = next_q.wdata[EV_W-1:0];
					REG_IRQ_MASK: if (next_q.wstrb[0]) next_q.mask = next_q.wdata[EV_W-1:0];
					default: begin
						for (int k = 0; k < NUM_LEDS; k++) begin
							if (widx == REG_DIRECT + 5'(k)) begin
								next_q.direct[k] = merge10(q.direct[k], next_q.wdata, next_q.wstrb);
							end
						end
					end
				endcase
			end
		end

		// Bus read channel
		unique case (ridx)
			REG_CTRL: rd = {31'h0000_0000, q.fe_en};
			REG_GAIN: rd = {24'h00_0000, q.gain};
			REG_WAKE: rd = {22'h00_0000, q.wake_th};
			REG_CLASS: rd = {22'h00_0000, q.class_th};
			REG_ALARM: rd = {22'h00_0000, q.alarm_th};
			REG_OFFSET: rd = {22'h00_0000, q.offset};
			REG_STATUS: rd = {23'h00_0000, q.led, q.st, q.classifying, q.nuis, q.alarm, q.fast};
			REG_IRQ_STAT: rd = {28'h000_0000, q.ev};
			REG_IRQ_MASK: rd = {28'h000_0000, q.mask};
			default: begin
				for (int k = 0; k < NUM_LEDS; k++) begin
					if (ridx == REG_DIRECT + 5'(k)) rd = {22'h00_0000, q.direct[k]};
					if (ridx == REG_RAW + 5'(k)) rd = {22'h00_0000, q.raw[k]};
					if (ridx == REG_CURR + 5'(k)) rd = q.curr[k];
					if (ridx == REG_RATIO + 5'(k)) rd = q.ratio[k];
				end
			end
		endcase
		if (rready && q.rvalid) begin
			next_q.rvalid = 1'b0;
		end
		if (arvalid && q.arready) begin
			next_q.rvalid = 1'b1;
			next_q.rdata = is_mapped(araddr) ? rd : 32'h0000_0000;
			next_q.rresp = is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
		end

		// Measurement sequencer
		if (q.st != ST_WAIT && q.timer != 32'h0000_0000) begin
			next_q.timer = q.timer - 32'h0000_0001;
		end
		unique case (q.st)
			ST_WAIT: begin
				if (!q.fe_en) begin
					next_q.timer = 32'(SLOW_CYC - 1);
					next_q.fast = 1'b0;
					next_q.alarm = 1'b0;
					next_q.nuis = 1'b0;
					next_q.classifying = 1'b0;
				end else if (q.timer == 32'h0000_0000) begin
					next_q.timer = q.fast ? 32'(FAST_CYC - 1) : 32'(SLOW_CYC - 1);
					next_q.led = LED_RED_FWD;
					next_q.st = ST_SAMPLE;
					next_q.led_on = 1'b1;
					next_q.adc_start = 1'b1;
				end else begin
					next_q.timer = q.timer - 32'h0000_0001;
				end
			end
			ST_SAMPLE: begin
				if (adc_in.valid) begin
					next_q.raw[q.led] = adc_in.code;
					next_q.led_on = 1'b0;
					next_q.div_start = 1'b1;
					next_q.st = ST_CURR_W;
				end
			end
			ST_CURR_W: begin
				if (div_done) begin
					next_q.curr[q.led] = div_quo;
					next_q.div_start = 1'b1;
					next_q.st = ST_RATIO_W;
				end
			end
			ST_RATIO_W: begin
				if (div_done) begin
					next_q.ratio[q.led] = div_quo;
					if (!q.fast) begin
						next_q.st = ST_WAIT;
						if (q.raw[LED_RED_FWD] > q.wake_th) begin
							next_q.fast = 1'b1;
							next_q.timer = 32'(FAST_CYC - 1);
							ev_set[EV_WAKE] = 1'b1;
						end
					end else if (q.led != LED_RED_BACK) begin
						next_q.led = (q.led == LED_RED_FWD) ? LED_BLUE_FWD : LED_RED_BACK;
						next_q.led_on = 1'b1;
						next_q.adc_start = 1'b1;
						next_q.st = ST_SAMPLE;
					end else begin
						next_q.st = ST_DECIDE;
					end
				end
			end
			ST_DECIDE: begin
				// Smoke and nuisance suppressed until red backward is above the classify level; alarm_now is not
				next_q.alarm = alarm_now || smoke_now;
				next_q.nuis = nuis_now && !alarm_now;
				next_q.classifying = cls_now;
				ev_set[EV_ALARM] = next_q.alarm && !q.alarm;
				ev_set[EV_NUIS] = next_q.nuis && !q.nuis;
				ev_set[EV_SCAN] = 1'b1;
				next_q.st = ST_WAIT;
				if (q.raw[LED_RED_FWD] < q.wake_th && !next_q.alarm) begin
					next_q.fast = 1'b0;
					next_q.timer = 32'(SLOW_CYC - 1);
				end else begin
					next_q.timer = 32'(FAST_CYC - 1);
				end
			end
			default: next_q.st = ST_WAIT;
		endcase

		// Offset compensation window
		next_q.oc_active = next_q.fe_en && (!next_q.gain[GAIN_OCS_BIT] || next_q.led_on);
		// Events: set wins over a clear in the same cycle
		next_q.ev = (q.ev & ~ev_clr) | ev_set;
		next_q.irq = |(next_q.ev & next_q.mask);
		next_q.awready = !next_q.aw_got && !next_q.bvalid;
		next_q.wready = !next_q.w_got && !next_q.bvalid;
		next_q.arready = !next_q.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= Q_RESET;
		end else if (clk_en) begin
			q <= next_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign awready = q.awready;
	assign wready = q.wready;
	assign bvalid = q.bvalid;
	assign bresp = q.bresp;
	assign arready = q.arready;
	assign rvalid = q.rvalid;
	assign rdata = q.rdata;
	assign rresp = q.rresp;
	assign led_out = '{on: q.led_on, sel: q.led, start: q.adc_start};
	assign frontend_enable = q.fe_en;
	assign offset_comp_active = q.oc_active;
	assign alarm = q.alarm;
	assign nuisance = q.nuis;
	assign irq = q.irq;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence scan_decided;
		q.st == ST_DECIDE && clk_en;
	endsequence

	sequence slow_ratio_done;
		q.st == ST_RATIO_W && div_done && clk_en && !q.fast;
	endsequence

	input_gain_reset_a: assert property ($rose(aresetn) |-> q.gain[GAIN_IG_LSB +: 2] == 2'h1)
		else $error("input gain field not at reset code");
	pga_gain_reset_a: assert property ($rose(aresetn) |-> q.gain[GAIN_PG_LSB +: 2] == 2'h2)
		else $error("pga gain field not at reset code");
	offset_comp_a: assert property (q.fe_en && q.gain[GAIN_OCS_BIT] && !q.led_on |-> !q.oc_active)
		else $error("offset compensation active with LED dark");
	wake_entry_a: assert property (slow_ratio_done ##0 q.raw[LED_RED_FWD] > q.wake_th
		|=> q.fast && q.timer == 32'(FAST_CYC - 1) && q.ev[EV_WAKE])
		else $error("fast scan not entered above wake threshold");
	classify_hold_a: assert property (scan_decided ##0 !cls_now && !alarm_now |=> !q.alarm && !q.nuis)
		else $error("decision made below classify threshold");
	smoke_alarm_a: assert property (scan_decided ##0 smoke_now |=> q.alarm && ($past(q.alarm) || q.ev[EV_ALARM]))
		else $error("blue over red did not alarm");
	hard_alarm_a: assert property (scan_decided ##0 q.raw[LED_RED_FWD] > q.alarm_th |=> q.alarm)
		else $error("alarm threshold crossed without alarm");
	slow_return_a: assert property (scan_decided ##0 q.raw[LED_RED_FWD] < q.wake_th && !alarm_now && !smoke_now
		|=> !q.fast && q.st == ST_WAIT)
		else $error("no return to slow scan");
	ratio_store_a: assert property (q.st == ST_RATIO_W && div_done && clk_en
		|=> q.ratio[$past(q.led)] == $past(div_quo))
		else $error("ratio not stored");
	current_operand_a: assert property (q.st == ST_CURR_W && q.div_start
		|-> div_den == {8'h00, gain_product(q.gain)} && div_num[31:21] == 11'h000)
		else $error("current conversion operands wrong");
endmodule
